// >>> core/mbi_consts.vh
// Constants for the host bus front end: mode codes, port functions,
// widths and reset values. Definitions only, shared by the decoder and the host port.
`ifndef MBI_CONSTS_VH
`define MBI_CONSTS_VH

// =====================================================================
// Host bus configurations
`define MBI_MODE_MUX8 2'h0
`define MBI_MODE_MUX16 2'h1
`define MBI_MODE_NMUX8 2'h2
`define MBI_MODE_NMUX16 2'h3

// =====================================================================
// Port A functions in the multiplexed configurations
`define MBI_PA_GPIO 2'h0
`define MBI_PA_ADDR_OUT 2'h1
`define MBI_PA_TRACK 2'h2

// =====================================================================
// Widths and field positions
`define MBI_ADDR_W 20
`define MBI_LINE_W 16
`define MBI_BYTE_W 8
`define MBI_PC_W 3
`define MBI_NUM_CS 8
`define MBI_CMP_W 9
`define MBI_CMP_LSB 11
`define MBI_A19_BIT 19

// =====================================================================
// Reset values
`define MBI_CS_IDLE 8'h00
`define MBI_BYTE_ZERO 8'h00
`define MBI_WORD_ZERO 16'h0000
`define MBI_ADDR_ZERO 20'h00000

`endif

// >>> core/mbi_addr_latch.v
// Address latch driven by the address latch strobe.
// Assumes the strobe and the data are synchronous to core_clk and that
// the strobe has already been reduced to an active-high level.
`timescale 1ns/1ps

module mbi_addr_latch #(
  parameter WIDTH = 16
) (
  input wire core_clk, // Core clock
  input wire rst_sync_n, // Synchronised reset, active low
  input wire strobe_active, // Latch strobe, active high
  input wire [WIDTH-1:0] d, // Live address inputs
  output wire [WIDTH-1:0] q // Latched address, transparent while open
);

  // =====================================================================
  // Storage
  reg [WIDTH-1:0] held;

  // Follow while open; the last value seen is kept at the trailing edge
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      held <= {WIDTH{1'b0}};
    end else if (strobe_active) begin
      held <= d;
    end
  end

  // Transparent while open, otherwise frozen so data phases do no harm
  assign q = strobe_active ? d : held;

endmodule

// >>> core/mbi_decode.v
// Chip select decoder: each select compares address bits 19..11 with a
// programmed value under a care mask. Assumes configuration is static
// while the host runs; output is combinational, registered by the caller.
`timescale 1ns/1ps
`include "mbi_consts.vh"

module mbi_decode #(
  parameter NUM_CS = `MBI_NUM_CS,
  parameter CMP_W = `MBI_CMP_W
) (
  input wire [`MBI_ADDR_W-1:0] addr, // Decoded address
  input wire [NUM_CS*CMP_W-1:0] cs_match, // Match values, packed
  input wire [NUM_CS*CMP_W-1:0] cs_mask, // Care bits, packed, 1 = compare
  output wire [NUM_CS-1:0] hit // Raw select hits, active high
);

  // =====================================================================
  // Compare field
  wire [CMP_W-1:0] field;
  assign field = addr[`MBI_CMP_LSB +: CMP_W];

  // One comparator per select
  genvar i;
  generate
    for (i = 0; i < NUM_CS; i = i + 1) begin : g_cs
      assign hit[i] = ((field ^ cs_match[i*CMP_W +: CMP_W])
                      & cs_mask[i*CMP_W +: CMP_W]) == {CMP_W{1'b0}};
    end
  endgenerate

endmodule

// >>> core/mbi_host_port.v
// Host bus front end: four bus configurations, address demultiplexing,
// upper address routing, port roles and chip select decoding.
// Assumes all host pins are synchronous to core_clk and that the
// configuration inputs are static while the host is active.
`timescale 1ns/1ps
`include "mbi_consts.vh"

module mbi_host_port #(
  parameter NUM_CS = `MBI_NUM_CS,
  parameter CMP_W = `MBI_CMP_W
) (
  input wire core_clk, // 40 MHz core clock
  input wire rst_n, // Asynchronous reset, active low
  input wire [1:0] bus_mode, // Host bus configuration
  input wire strobe_high_active, // Strobe polarity, 1 = active high
  input wire nmux_use_strobe, // Latch address in non-mux modes
  input wire csi_select, // Shared pin is chip select, not A19
  input wire [2:0] pc_addr_latch, // Port C bits latched by strobe
  input wire [1:0] pa_func, // Port A role in mux modes
  input wire [7:0] pa_gpio_out, // Port A GPIO output values
  input wire [7:0] pa_gpio_dir, // Port A GPIO directions, 1 = out
  input wire [7:0] pb_gpio_out, // Port B GPIO output values
  input wire [7:0] pb_gpio_dir, // Port B GPIO directions, 1 = out
  input wire [7:0] pb_cs_sel, // Port B bit is a chip select
  input wire [NUM_CS*CMP_W-1:0] cs_match, // Decoder match values
  input wire [NUM_CS*CMP_W-1:0] cs_mask, // Decoder care bits
  input wire address_latch_strobe, // Host address latch strobe
  input wire addr19_or_chip_select_in, // A19 or chip select, low active
  input wire host_rd_n, // Host read strobe, active low
  input wire host_wr_n, // Host write strobe, active low
  input wire [15:0] addr_data_lines_in, // Address/data lines, in
  output reg [15:0] addr_data_lines_out, // Address/data lines, out
  output reg [15:0] addr_data_lines_oe, // Address/data lines, enable
  input wire [7:0] port_a_in, // Port A pins, in
  output reg [7:0] port_a_out, // Port A pins, out
  output reg [7:0] port_a_oe, // Port A pins, enable
  input wire [7:0] port_b_in, // Port B pins, in
  output reg [7:0] port_b_out, // Port B pins, out
  output reg [7:0] port_b_oe, // Port B pins, enable
  input wire [2:0] port_c_in, // Port C address pins
  input wire [15:0] core_rdata, // Read data from the memory side
  output reg [19:0] core_addr, // Decoded host address
  output reg [15:0] core_wdata, // Write data to the memory side
  output reg core_wr, // Write pulse at end of host write
  output reg [7:0] port_a_gpio_in, // Port A pin levels as seen
  output reg [7:0] port_b_gpio_in, // Port B pin levels as seen
  output reg [NUM_CS-1:0] decoder_chip_selects, // Selects, active high
  output reg power_down // Decoder in standby
);

  // =====================================================================
  // Reset synchroniser
  reg rst_meta_n;
  reg rst_sync_n;

  // Release through two flops; assertion stays asynchronous
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // =====================================================================
  // Mode decode
  wire mode_mux;
  wire mode_wide;
  wire mode_nm16;

  // Four configurations from two bits, none left over
  assign mode_mux = (bus_mode == `MBI_MODE_MUX8) ||
                    (bus_mode == `MBI_MODE_MUX16);
  assign mode_wide = (bus_mode == `MBI_MODE_MUX16) ||
                     (bus_mode == `MBI_MODE_NMUX16);
  assign mode_nm16 = (bus_mode == `MBI_MODE_NMUX16);

  // =====================================================================
  // Strobe polarity and latch enables
  wire strobe_active;
  wire lo_latch_en;
  wire hi_latch_en;
  wire [2:0] pc_latch_en;

  // Polarity is chosen so the falling of the active level is the capture
  assign strobe_active = address_latch_strobe ^ ~strobe_high_active;

  // Non-mux hosts may still use the strobe when data sits on the ports
  assign lo_latch_en = mode_mux ? strobe_active :
                       (nmux_use_strobe ? strobe_active : 1'b1);
  // The high byte is only multiplexed in the wide multiplexed mode
  assign hi_latch_en = (mode_mux && mode_wide) ? strobe_active :
                       (!mode_mux && nmux_use_strobe) ? strobe_active :
                       1'b1;
  assign pc_latch_en[0] = pc_addr_latch[0] ? strobe_active : 1'b1;
  assign pc_latch_en[1] = pc_addr_latch[1] ? strobe_active : 1'b1;
  assign pc_latch_en[2] = pc_addr_latch[2] ? strobe_active : 1'b1;

  // =====================================================================
  // Address latches
  wire [7:0] addr_lo;
  wire [7:0] addr_hi;
  wire [2:0] addr_pc;

  // Low byte shares data in mux modes, so it is captured by the strobe
  mbi_addr_latch #(.WIDTH(`MBI_BYTE_W)) u_latch_lo (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .strobe_active(lo_latch_en),
    .d(addr_data_lines_in[7:0]),
    .q(addr_lo)
  );

  // High byte latched in the wide mux mode, or in non-mux modes with nmux_use_strobe
  mbi_addr_latch #(.WIDTH(`MBI_BYTE_W)) u_latch_hi (
    .core_clk(core_clk),
    .rst_sync_n(rst_sync_n),
    .strobe_active(hi_latch_en),
    .d(addr_data_lines_in[15:8]),
    .q(addr_hi)
  );

  // Port C bits use one latch each with their own enable
  genvar gi;
  generate
    for (gi = 0; gi < `MBI_PC_W; gi = gi + 1) begin : g_pc
      mbi_addr_latch #(.WIDTH(1)) u_latch_pc (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .strobe_active(pc_latch_en[gi]),
        .d(port_c_in[gi]),
        .q(addr_pc[gi])
      );
    end
  endgenerate

  // =====================================================================
  // Full decoder address
  wire addr19;
  wire [`MBI_ADDR_W-1:0] dec_addr;
  wire [NUM_CS-1:0] dec_hit;
  wire csi_off;

  // Shared pin feeds bit 19 only when it is not the chip select
  assign addr19 = csi_select ? 1'b0 : addr19_or_chip_select_in;
  // Held latches keep selects steady across data phases
  assign dec_addr = {addr19, addr_pc, addr_hi, addr_lo};
  // Chip select input high puts the decoder in standby
  assign csi_off = csi_select && addr19_or_chip_select_in;

  mbi_decode #(.NUM_CS(NUM_CS), .CMP_W(CMP_W)) u_decode (
    .addr(dec_addr),
    .cs_match(cs_match),
    .cs_mask(cs_mask),
    .hit(dec_hit)
  );

  // =====================================================================
  // Data phase qualifiers
  wire rd_active;
  wire wr_active;
  wire [15:0] host_wdata;
  reg wr_prev;
  reg [15:0] wdata_hold;

  // Reads and writes only while the decoder is awake
  assign rd_active = !host_rd_n && !csi_off;
  assign wr_active = !host_wr_n && !csi_off;

  // Where the host data sits depends on the configuration
  assign host_wdata = mode_mux ?
                      {(mode_wide ? addr_data_lines_in[15:8] :
                        `MBI_BYTE_ZERO), addr_data_lines_in[7:0]} :
                      {(mode_wide ? port_b_in : `MBI_BYTE_ZERO),
                       port_a_in};

  // Data is kept from the last active cycle, since the host may drop
  // it together with the strobe
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_prev <= 1'b0;
      wdata_hold <= `MBI_WORD_ZERO;
    end else begin
      wr_prev <= wr_active;
      if (wr_active) begin
        wdata_hold <= host_wdata;
      end
    end
  end

  // =====================================================================
  // Address/data line drive
  reg [15:0] next_ad_out;
  reg [15:0] next_ad_oe;

  // Lines are address inputs except during a read in mux modes
  always @* begin
    next_ad_out = `MBI_WORD_ZERO;
    next_ad_oe = `MBI_WORD_ZERO;
    if (mode_mux && rd_active) begin
      next_ad_out[7:0] = core_rdata[7:0];
      next_ad_oe[7:0] = 8'hff;
      if (mode_wide) begin
        next_ad_out[15:8] = core_rdata[15:8];
        next_ad_oe[15:8] = 8'hff;
      end
    end
  end

  // =====================================================================
  // Port A function
  reg [7:0] next_pa_out;
  reg [7:0] next_pa_oe;

  // Non-mux: data bus. Mux: GPIO, address out or tracking the bus
  always @* begin
    next_pa_out = pa_gpio_out;
    next_pa_oe = pa_gpio_dir;
    if (!mode_mux) begin
      next_pa_out = core_rdata[7:0];
      next_pa_oe = rd_active ? 8'hff : `MBI_BYTE_ZERO;
    end else begin
      case (pa_func)
        `MBI_PA_GPIO: begin
          next_pa_out = pa_gpio_out;
          next_pa_oe = pa_gpio_dir;
        end
        `MBI_PA_ADDR_OUT: begin
          next_pa_out = addr_lo;
          next_pa_oe = 8'hff;
        end
        `MBI_PA_TRACK: begin
          // Copies whatever is on the low lines, either direction
          next_pa_out = rd_active ? core_rdata[7:0] :
                        addr_data_lines_in[7:0];
          next_pa_oe = 8'hff;
        end
        default: begin
          next_pa_out = pa_gpio_out;
          next_pa_oe = pa_gpio_dir;
        end
      endcase
    end
  end

  // =====================================================================
  // Port B function
  reg [7:0] next_pb_out;
  reg [7:0] next_pb_oe;
  reg [NUM_CS-1:0] next_cs;
  integer bi;

  // Standby and reset both force every select inactive
  always @* begin
    next_cs = csi_off ? {NUM_CS{1'b0}} : dec_hit;
  end

  // High data byte in wide non-mux mode, else per-bit GPIO or select
  always @* begin
    next_pb_out = `MBI_BYTE_ZERO;
    next_pb_oe = `MBI_BYTE_ZERO;
    if (mode_nm16) begin
      next_pb_out = core_rdata[15:8];
      next_pb_oe = rd_active ? 8'hff : `MBI_BYTE_ZERO;
    end else begin
      for (bi = 0; bi < 8; bi = bi + 1) begin
        if (pb_cs_sel[bi]) begin
          next_pb_out[bi] = next_cs[bi];
          next_pb_oe[bi] = 1'b1;
        end else begin
          next_pb_out[bi] = pb_gpio_out[bi];
          next_pb_oe[bi] = pb_gpio_dir[bi];
        end
      end
    end
  end

  // =====================================================================
  // Output registers
  // One cycle of latency buys glitch-free pins straight from flops
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      addr_data_lines_out <= `MBI_WORD_ZERO;
      addr_data_lines_oe <= `MBI_WORD_ZERO;
      port_a_out <= `MBI_BYTE_ZERO;
      port_a_oe <= `MBI_BYTE_ZERO;
      port_b_out <= `MBI_BYTE_ZERO;
      port_b_oe <= `MBI_BYTE_ZERO;
      core_addr <= `MBI_ADDR_ZERO;
      core_wdata <= `MBI_WORD_ZERO;
      core_wr <= 1'b0;
      port_a_gpio_in <= `MBI_BYTE_ZERO;
      port_b_gpio_in <= `MBI_BYTE_ZERO;
      decoder_chip_selects <= `MBI_CS_IDLE;
      power_down <= 1'b0;
    end else begin
      addr_data_lines_out <= next_ad_out;
      addr_data_lines_oe <= next_ad_oe;
      port_a_out <= next_pa_out;
      port_a_oe <= next_pa_oe;
      port_b_out <= next_pb_out;
      port_b_oe <= next_pb_oe;
      core_addr <= dec_addr;
      // Write lands on the trailing edge of the host write strobe
      core_wr <= wr_prev && !wr_active && !csi_off;
      // A write cut short by standby must not disturb the last data
      if (wr_prev && !wr_active && !csi_off) begin
        core_wdata <= wdata_hold;
      end
      port_a_gpio_in <= port_a_in;
      port_b_gpio_in <= port_b_in;
      decoder_chip_selects <= next_cs;
      power_down <= csi_off;
    end
  end

endmodule

// >>> testbench/mbi_host_port_props.sv
// Checker for the host bus front end: latch, lane and standby relations.
// Sees the top module's ports only; bound to it at the foot of the file.
`timescale 1ns/1ps
module mbi_host_port_props #(
  parameter NUM_CS = 8
) (
  input wire core_clk, // Core clock
  input wire rst_n, // Reset, active low
  input wire [1:0] bus_mode, // Configuration
  input wire strobe_high_active, // Strobe polarity
  input wire csi_select, // Shared pin role
  input wire [2:0] pc_addr_latch, // Port C latch enables
  input wire address_latch_strobe, // Strobe pin
  input wire addr19_or_chip_select_in, // Shared pin
  input wire host_rd_n, // Read strobe
  input wire [15:0] addr_data_lines_in, // Lines in
  input wire [15:0] addr_data_lines_out, // Lines out
  input wire [15:0] addr_data_lines_oe, // Lines enable
  input wire [7:0] port_a_out, // Port A out
  input wire [7:0] port_a_oe, // Port A enable
  input wire [7:0] port_b_out, // Port B out
  input wire [7:0] port_b_oe, // Port B enable
  input wire [2:0] port_c_in, // Port C pins
  input wire [15:0] core_rdata, // Memory read data
  input wire [19:0] core_addr, // Decoded address
  input wire [NUM_CS-1:0] decoder_chip_selects, // Selects
  input wire power_down // Standby
);
  // =====================================================================
  // Helpers
  // Outputs are zero for two edges after release, so wait three
  reg [1:0] up_cnt;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
  end
  wire up = (up_cnt == 2'h3);
  wire stb = (address_latch_strobe == strobe_high_active);
  wire rd_ok = up && !host_rd_n && !(csi_select && addr19_or_chip_select_in);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // =====================================================================
  // Assertions
  lo_capture_a: assert property (
    (up && !bus_mode[1] && stb) |=>
    core_addr[7:0] == $past(addr_data_lines_in[7:0]))
    else $error("low capture");
  hi_capture_a: assert property (
    (up && bus_mode == 2'h1 && stb) |=>
    core_addr[15:8] == $past(addr_data_lines_in[15:8]))
    else $error("high capture");
  addr_hold_a: assert property (
    (up && !bus_mode[1] && !stb && $stable(bus_mode)) |=>
    $stable(core_addr[7:0])) else $error("address moved");
  pc_latch_a: assert property (
    (up && pc_addr_latch == 3'h7 && stb) |=>
    core_addr[18:16] == $past(port_c_in)) else $error("port c capture");
  pc_live_a: assert property (
    (up && pc_addr_latch == 3'h0) |=>
    core_addr[18:16] == $past(port_c_in)) else $error("port c live");
  mux8_read_a: assert property (
    (rd_ok && bus_mode == 2'h0) |=> addr_data_lines_oe == 16'h00ff &&
    addr_data_lines_out[7:0] == $past(core_rdata[7:0]))
    else $error("mux8 read");
  mux16_read_a: assert property (
    (rd_ok && bus_mode == 2'h1) |=> addr_data_lines_oe == 16'hffff &&
    addr_data_lines_out == $past(core_rdata)) else $error("mux16 read");
  nmux8_read_a: assert property (
    (rd_ok && bus_mode == 2'h2) |=> port_a_oe == 8'hff &&
    port_a_out == $past(core_rdata[7:0])) else $error("nmux8 read");
  nmux16_read_a: assert property (
    (rd_ok && bus_mode == 2'h3) |=> port_a_oe == 8'hff && port_b_oe == 8'hff
    && {port_b_out, port_a_out} == $past(core_rdata))
    else $error("nmux16 read");
  nmux_addr_a: assert property (
    (up && bus_mode[1]) |=> addr_data_lines_oe == 16'h0000)
    else $error("lines driven");
  standby_a: assert property (
    (up && csi_select && addr19_or_chip_select_in) |=>
    decoder_chip_selects == 0 && power_down) else $error("standby");
endmodule

bind mbi_host_port mbi_host_port_props #(.NUM_CS(NUM_CS)) i_props (.*);

// >>> testbench/mbi_host_model.sv
// Host model: a processor bus master wired for any of the four modes.
// Assumes the device samples its pins on the rising core clock edge.
`timescale 1ns/1ps
module mbi_host_model (
  input wire core_clk, // Core clock
  input wire [1:0] bus_mode, // Wiring of this host
  input wire strobe_high_active, // Strobe polarity
  input wire [15:0] addr_data_lines_out, // Device line drive
  input wire [15:0] addr_data_lines_oe, // Device line enable
  input wire [7:0] port_a_out, // Device port A drive
  input wire [7:0] port_a_oe, // Device port A enable
  input wire [7:0] port_b_out, // Device port B drive
  input wire [7:0] port_b_oe, // Device port B enable
  output wire address_latch_strobe, // Strobe pin
  output reg addr19_or_chip_select_in, // A19 or select
  output reg host_rd_n, // Read strobe
  output reg host_wr_n, // Write strobe
  output wire [15:0] addr_data_lines_in, // Resolved lines
  output wire [7:0] port_a_in, // Resolved port A
  output wire [7:0] port_b_in, // Resolved port B
  output reg [2:0] port_c_in // Upper address
);
  reg stb_act = 1'b0;
  reg [15:0] h_ad = 16'h0000;
  reg [15:0] h_ad_en = 16'h0000;
  reg [15:0] h_pd = 16'h0000;
  reg [15:0] h_pd_en = 16'h0000;

  // Released lines show the inverse of the last host value, never a copy
  assign addr_data_lines_in = (addr_data_lines_oe & addr_data_lines_out) |
    (~addr_data_lines_oe & (h_ad ^ ~h_ad_en));
  assign port_a_in = (port_a_oe & port_a_out) |
    (~port_a_oe & (h_pd[7:0] ^ ~h_pd_en[7:0]));
  assign port_b_in = (port_b_oe & port_b_out) |
    (~port_b_oe & (h_pd[15:8] ^ ~h_pd_en[15:8]));
  assign address_latch_strobe = stb_act ~^ strobe_high_active;

  initial begin
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    addr19_or_chip_select_in = 1'b0;
    port_c_in = 3'h0;
  end

  // Address phase, data phase of two edges, then one idle edge
  task automatic bus_cycle(input [19:0] addr, input wr, input [15:0] wd,
                           input scr, output [15:0] rdv);
    begin
      stb_act <= 1'b1;
      h_ad <= addr[15:0];
      h_ad_en <= 16'hffff;
      h_pd_en <= 16'h0000;
      port_c_in <= addr[18:16];
      addr19_or_chip_select_in <= addr[19];
      @(posedge core_clk);
      stb_act <= 1'b0;
      if (scr)
        port_c_in <= ~addr[18:16];
      if (bus_mode[1]) begin
        // Data on the ports; scrambled lines need the strobe
        if (scr)
          h_ad <= ~addr[15:0];
        h_pd <= wd;
        h_pd_en <= {{8{wr & bus_mode[0]}}, {8{wr}}};
      end else begin
        h_ad <= bus_mode[0] ? wd : {addr[15:8], wd[7:0]};
        h_ad_en <= bus_mode[0] ? {16{wr}} : {8'hff, {8{wr}}};
      end
      if (wr)
        host_wr_n <= 1'b0;
      else
        host_rd_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rdv = bus_mode[1] ? {port_b_in, port_a_in} : addr_data_lines_in;
      host_rd_n <= 1'b1;
      host_wr_n <= 1'b1;
      @(posedge core_clk);
    end
  endtask
endmodule

// >>> testbench/mcu_bus_mode_interface_tb.sv
// Testbench for the host bus front end: all modes and polarities,
// lanes, live path, selects, standby and port roles.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module mcu_bus_mode_interface_tb;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [1:0] bus_mode = 2'h0;
  reg strobe_high_active = 1'b1;
  reg nmux_use_strobe = 1'b1;
  reg csi_select = 1'b0;
  reg [2:0] pc_addr_latch = 3'h7;
  reg [1:0] pa_func = 2'h0;
  reg [7:0] pa_gpio_out = 8'h00, pa_gpio_dir = 8'h00;
  reg [7:0] pb_gpio_out = 8'h00, pb_gpio_dir = 8'h00, pb_cs_sel = 8'h00;
  reg [71:0] cs_match = 72'h055, cs_mask = 72'h1ff;
  reg [15:0] core_rdata = 16'h0000;
  wire address_latch_strobe, addr19_or_chip_select_in, host_rd_n, host_wr_n;
  wire [15:0] addr_data_lines_in, addr_data_lines_out, addr_data_lines_oe;
  wire [7:0] port_a_in, port_a_out, port_a_oe, port_a_gpio_in;
  wire [7:0] port_b_in, port_b_out, port_b_oe, port_b_gpio_in;
  wire [7:0] decoder_chip_selects;
  wire [2:0] port_c_in;
  wire [19:0] core_addr;
  wire [15:0] core_wdata, msk;
  wire core_wr, power_down;
  integer num_errors = 0, n_compared = 0, m, k;
  reg [15:0] rd;
  reg seen_wr;

  always #12.5 core_clk = ~core_clk;
  mbi_host_port i_dut (.*);
  mbi_host_model i_host (.*);
  assign msk = bus_mode[0] ? 16'hffff : 16'h00ff;

  // =====================================================================
  // Checking and closing
  task check(input string what, input [31:0] seen, input [31:0] expv);
    begin
      n_compared = n_compared + 1;
      if (seen !== expv) begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", what, expv, seen);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Write then read back one address; wait bounded for the write pulse
  task xfer(input [19:0] addr, input [15:0] wd, input scr);
    begin
      i_host.bus_cycle(addr, 1'b1, wd, scr, rd);
      k = 0;
      while (core_wr !== 1'b1 && k < 6) begin
        @(posedge core_clk);
        k = k + 1;
      end
      check("write pulse", core_wr, 1'b1);
      check("wdata", core_wdata, wd & msk);
      check("addr", core_addr, addr);
      core_rdata <= ~wd;
      i_host.bus_cycle(addr, 1'b0, 16'h0000, scr, rd);
      check("rdata", rd & msk, ~wd & msk);
    end
  endtask

  // Hang guard, well beyond the roughly 125 cycles the tests need
  initial begin
    #(3000 * 25);
    num_errors = num_errors + 1;
    report_and_stop;
  end

  // =====================================================================
  // Tests
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (m = 0; m < 8; m = m + 1) begin
      bus_mode <= m[1:0];
      strobe_high_active <= m[2];
      repeat (2) @(posedge core_clk);
      xfer(20'h6b5a3 + 20'h11111 * m[19:0], 16'hc31e + m[15:0],
           1'b1);
      $display("test mode %0d polarity %0d done", m[1:0], m[2]);
    end
    // Non-multiplexed host with live address lines and live port C
    bus_mode <= 2'h2;
    nmux_use_strobe <= 1'b0;
    pc_addr_latch <= 3'h0;
    repeat (2) @(posedge core_clk);
    xfer(20'h5e3c1, 16'h0ff0, 1'b0);
    $display("test live address done");
    // Port roles and selects in the multiplexed 8-bit mode
    bus_mode <= 2'h0;
    pc_addr_latch <= 3'h7;
    csi_select <= 1'b1;
    pb_cs_sel <= 8'h01;
    pb_gpio_out <= 8'ha4;
    pb_gpio_dir <= 8'hfe;
    pa_gpio_out <= 8'h5c;
    pa_gpio_dir <= 8'hf0;
    repeat (2) @(posedge core_clk);
    i_host.bus_cycle(20'h2a8c7, 1'b0, 16'h0000, 1'b0, rd);
    check("selects hit", decoder_chip_selects, 8'hff);
    check("power", power_down, 1'b0);
    check("port b", port_b_out, 8'ha5);
    check("port b oe", port_b_oe, 8'hff);
    check("port a oe", port_a_oe, 8'hf0);
    check("port a", port_a_out & 8'hf0, 8'h50);
    check("port a in", port_a_gpio_in & 8'hf0, 8'h50);
    check("port b in", port_b_gpio_in, 8'ha5);
    pa_func <= 2'h1;
    repeat (2) @(posedge core_clk);
    check("port a addr", port_a_out, 8'hc7);
    check("port a addr oe", port_a_oe, 8'hff);
    // Track mode: read data during the read, live low lines otherwise
    pa_func <= 2'h2;
    i_host.bus_cycle(20'h00000, 1'b0, 16'h0000, 1'b0, rd);
    check("selects miss", decoder_chip_selects, 8'hfe);
    check("port a track rd", port_a_out, 8'h0f);
    check("port a track oe", port_a_oe, 8'hff);
    $display("test port roles done");
    // Chip select held high: no selects, no write, standby
    i_host.bus_cycle(20'haa800, 1'b1, 16'h1234, 1'b0, rd);
    seen_wr = 1'b0;
    repeat (4) begin
      @(posedge core_clk);
      seen_wr = seen_wr | core_wr;
    end
    check("standby write", seen_wr, 1'b0);
    check("standby wdata", core_wdata, 16'h00f0);
    check("standby selects", decoder_chip_selects, 8'h00);
    check("standby power", power_down, 1'b1);
    check("standby track", port_a_out, 8'h34);
    $display("test standby done");
    report_and_stop;
  end
endmodule
